// >>> rtl/threshold_relay_controller.v
// Our own choices: the APB register port and the register addresses.
`include "relay_ctrl_map.vh"
module threshold_relay_controller #(
    parameter TICK_CYCLES = `TICK_NS / `CLK_NS // Cycles per 0.1 s
) (
    input wire clk, // 50 MHz clock
    input wire srst, // Sync reset, high
    input wire ce, // Clock enable
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [7:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output wire pready, // APB ready
    output wire pslverr, // APB error
    input wire [15:0] measured_value, // Signed result
    input wire range_exceeded, // Measurement out of range
    input wire frame_received, // Serial frame pulse
    input wire serial_cmd_valid, // Relay command pulse
    input wire [1:0] serial_relay_cmd, // Relay command bits
    input wire key_press, // Any local key pulse
    input wire escape_key, // Escape key pulse
    output reg [1:0] relay_out, // Relay drive
    output wire [1:0] relay_led, // Relay indicator LEDs
    output reg colour_red, // Display red
    output reg colour_green, // Display green
    output reg [15:0] displayed_value // Value shown
);
    // ----------------------------------------
    // Local constants
    // ----------------------------------------
    // Full-width copy first, so the cut to the counter width is explicit
    localparam [31:0] TICK_LAST_FULL = TICK_CYCLES - 1;
    localparam [22:0] TICK_LAST = TICK_LAST_FULL[22:0];

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0] ctrl;
    reg [15:0] time_cfg;
    reg [25:0] cthr;
    reg [15:0] pmin;
    reg [31:0] rcfg [0:1];
    reg [31:0] rthr [0:1];
    reg [25:0] rdly [0:1];
    reg [1:0] scmd;
    reg [22:0] tcnt;
    reg tick;
    reg [3:0] sub;
    reg [6:0] gap;
    reg frame_alarm;
    reg [15:0] track;
    reg [15:0] peak;
    reg hold_on;
    reg [7:0] htmr;
    reg pending;
    // Per-channel evaluated state, one driver per bit
    wire [1:0] state;
    reg alarm_q;
    reg extra_q;
    wire [1:0] next_relay;
    wire [1:0] crit;
    wire [15:0] held = hold_on ? peak : measured_value;
    // Address decode; the spare relay slot answers with an error
    wire acc = psel & penable;
    wire rsel = (paddr[7:5] == `OFF_RELAY);
    wire ri = paddr[4];
    wire mapped = rsel ? (paddr[3:2] != 2'b11) : (paddr <= `OFF_STAT);

    // Zero wait states; LED is a plain copy so it never lags the coil
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign relay_led = relay_out;

    // ----------------------------------------
    // APB register file
    // ----------------------------------------
    // Writes take effect on the access cycle only
    always @(posedge clk) begin
        if (srst) begin
            ctrl <= 8'h00;
            time_cfg <= 16'h0000;
            cthr <= 26'h0000000;
            pmin <= 16'h0000;
            rcfg[0] <= 32'h00000000;
            rcfg[1] <= 32'h00000000;
            rthr[0] <= 32'h00000000;
            rthr[1] <= 32'h00000000;
            rdly[0] <= 26'h0000000;
            rdly[1] <= 26'h0000000;
        end else if (ce && acc && pwrite && mapped) begin
            if (rsel) begin
                case (paddr[3:2])
                    `OFF_RCFG: rcfg[ri] <= {6'h00, pwdata[25:16], 8'h00, pwdata[7:0]};
                    `OFF_RTHR: rthr[ri] <= pwdata;
                    `OFF_RDLY: rdly[ri] <= {pwdata[25:16], 6'h00, pwdata[9:0]};
                    default: ;
                endcase
            end else begin
                case (paddr)
                    `OFF_CTRL: ctrl <= {1'b0, pwdata[6:0]};
                    `OFF_TIME: time_cfg <= pwdata[15:0];
                    `OFF_CTHR: cthr <= {pwdata[25:16], pwdata[15:0]};
                    `OFF_PMIN: pmin <= pwdata[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Read mux; status reflects live block state
    always @* begin
        prdata = 32'h00000000;
        if (rsel) begin
            case (paddr[3:2])
                `OFF_RCFG: prdata = rcfg[ri];
                `OFF_RTHR: prdata = rthr[ri];
                `OFF_RDLY: prdata = {6'h00, rdly[ri]};
                default: prdata = 32'h00000000;
            endcase
        end else begin
            case (paddr)
                `OFF_CTRL: prdata = {24'h000000, ctrl};
                `OFF_TIME: prdata = {16'h0000, time_cfg};
                `OFF_CTHR: prdata = {6'h00, cthr};
                `OFF_PMIN: prdata = {16'h0000, pmin};
                `OFF_STAT: prdata = {held, 8'h00, hold_on, frame_alarm, range_exceeded,
                                     pending, state, relay_out};
                default: prdata = 32'h00000000;
            endcase
        end
    end

    // ----------------------------------------
    // 0.1 s tick, second count, frame supervision
    // ----------------------------------------
    // One common tick keeps all delays aligned
    always @(posedge clk) begin
        if (srst) begin
            tcnt <= 23'h000000;
            tick <= 1'b0;
            sub <= 4'h0;
            gap <= 7'h00;
            frame_alarm <= 1'b0;
            scmd <= 2'b00;
        end else if (ce) begin
            tick <= (tcnt == TICK_LAST);
            tcnt <= (tcnt == TICK_LAST) ? 23'h000000 : tcnt + 23'h000001;
            if (serial_cmd_valid)
                scmd <= serial_relay_cmd;
            if (frame_received) begin
                sub <= 4'h0;
                gap <= 7'h00;
            end else if (tick) begin
                sub <= (sub == `TICKS_PER_SEC) ? 4'h0 : sub + 4'h1;
                if (sub == `TICKS_PER_SEC && gap != `TMO_MAX)
                    gap <= gap + 7'h01;
            end
            // Zero timeout switches supervision off
            frame_alarm <= (time_cfg[6:0] != 7'h00) && (gap > time_cfg[6:0]);
        end
    end

    // ----------------------------------------
    // Peak or drop detection and hold
    // ----------------------------------------
    // Swing is measured back from the tracked extreme
    wire inv = ctrl[`CTRL_INV];
    wire signed [16:0] mv = {measured_value[15], measured_value};
    wire signed [16:0] tv = {track[15], track};
    wire signed [16:0] swing = inv ? mv - tv : tv - mv;
    wire beyond = inv ? (mv < tv) : (mv > tv);
    wire found = swing >= $signed({1'b0, pmin});

    // Track follows the extreme; a big enough swing back registers it
    always @(posedge clk) begin
        if (srst) begin
            track <= 16'h0000;
            peak <= 16'h0000;
            hold_on <= 1'b0;
            htmr <= 8'h00;
        end else if (ce) begin
            if (beyond)
                track <= measured_value;
            else if (found) begin
                peak <= track;
                track <= measured_value;
                hold_on <= 1'b1;
                htmr <= 8'h00;
            end
            if (hold_on && !(found && !beyond)) begin
                if (time_cfg[15:8] == 8'h00) begin
                    // Zero: hold until escape, or no hold at all
                    if (!ctrl[`CTRL_DISPLAYED_VALUE_SELECT] || escape_key)
                        hold_on <= 1'b0;
                end else if (escape_key || htmr >= time_cfg[15:8])
                    hold_on <= 1'b0;
                else if (tick)
                    htmr <= htmr + 8'h01;
            end
        end
    end

    // ----------------------------------------
    // Relay channels
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : ch
            // Per-relay configuration fields and window borders
            wire [2:0] mode = rcfg[g][2:0];
            wire [1:0] react = rcfg[g][4:3];
            wire [15:0] v = rcfg[g][`RCFG_SRC] ? held : measured_value;
            wire signed [17:0] x = {{2{v[15]}}, v};
            wire signed [17:0] h = {8'h00, rcfg[g][25:16]};
            wire signed [17:0] t1 = {{2{rthr[g][15]}}, rthr[g][15:0]};
            wire signed [17:0] t2 = {{2{rthr[g][31]}}, rthr[g][31:16]};
            wire signed [17:0] hi = (t1 > t2) ? t1 : t2;
            wire signed [17:0] lo = (t1 > t2) ? t2 : t1;
            wire in_on = (x > lo + h) && (x < hi - h);
            wire out_on = (x > hi + h) || (x < lo - h);
            // Condition flags and delay counters of this relay
            reg on_c;
            reg off_c;
            reg [9:0] dcnt;
            reg [5:0] pre;
            reg st;
            // Evaluated state is exported one bit per channel
            assign state[g] = st;
            wire serial = (mode == `MODE_SERIAL);
            wire thr_mode = (mode != `MODE_INACT) && !serial;
            // Frame gap matters only when serial drives the relay
            assign crit[g] = serial ? frame_alarm : range_exceeded;
            wire [9:0] dly = state[g] ? rdly[g][25:16] : rdly[g][9:0];
            wire want = state[g] ? off_c : on_c;
            wire step = tick && (!rcfg[g][`RCFG_UNIT] || pre == `TICKS_PER_MIN_STEP);
            wire freeze = crit[g] && (react == `REACT_KEEP);

            // Switching conditions per mode
            always @* begin
                on_c = 1'b0;
                off_c = 1'b0;
                case (mode)
                    `MODE_DIRECT: begin
                        on_c = x > t1 + h;
                        off_c = x < t1 - h;
                    end
                    `MODE_INVERT: begin
                        on_c = x < t1 - h;
                        off_c = x > t1 + h;
                    end
                    `MODE_INSIDE: begin
                        on_c = in_on;
                        off_c = (x < lo - h) || (x > hi + h);
                    end
                    `MODE_OUTSIDE: begin
                        on_c = out_on;
                        off_c = (x > lo + h) && (x < hi - h);
                    end
                    default: begin
                        on_c = 1'b0;
                        off_c = 1'b0;
                    end
                endcase
            end

            // Delay count restarts whenever the condition drops
            always @(posedge clk) begin
                if (srst) begin
                    st <= 1'b0;
                    dcnt <= 10'h000;
                    pre <= 6'h00;
                end else if (ce && !freeze) begin
                    if (serial) begin
                        st <= scmd[g];
                        dcnt <= 10'h000;
                    end else if (!thr_mode) begin
                        st <= 1'b0;
                        dcnt <= 10'h000;
                    end else if (!want) begin
                        dcnt <= 10'h000;
                        pre <= 6'h00;
                    end else if (dcnt >= dly) begin
                        st <= ~st;
                        dcnt <= 10'h000;
                        pre <= 6'h00;
                    end else if (tick) begin
                        pre <= step ? 6'h00 : pre + 6'h01;
                        if (step)
                            dcnt <= dcnt + 10'h001;
                    end
                end
            end

            // Alarm reaction overrides the evaluated state
            assign next_relay[g] = !crit[g] ? state[g] :
                                   (react == `REACT_ON) ? 1'b1 :
                                   (react == `REACT_OFF) ? 1'b0 : state[g];
        end
    endgenerate

    // ----------------------------------------
    // Outputs and display colour
    // ----------------------------------------
    // Extra colour threshold works on the live value only
    wire signed [17:0] cv = {{2{measured_value[15]}}, measured_value};
    wire signed [17:0] ct = {{2{cthr[15]}}, cthr[15:0]};
    wire signed [17:0] chy = {8'h00, cthr[25:16]};
    wire extra_live = ctrl[`CTRL_CPR] &&
                      (ctrl[`CTRL_DIR] ? (cv < ct + chy) : (cv > ct + chy));
    wire alarm_live = ctrl[`CTRL_CAL] && (range_exceeded || frame_alarm);
    // Colour events are edges, so a steady condition does not re-arm
    wire [1:0] fol = {rcfg[1][`RCFG_CFOL], rcfg[0][`RCFG_CFOL]};
    wire [1:0] rel_live = fol & next_relay;
    wire [1:0] rel_rise = rel_live & ~relay_out;
    wire event_now = (|rel_rise) || (alarm_live && !alarm_q) || (extra_live && !extra_q);
    wire live = (|rel_live) || alarm_live || extra_live;
    wire ack = ctrl[`CTRL_ACK] && key_press;
    // New events win over a simultaneous acknowledge
    wire next_pending = event_now ? 1'b1 :
                        ctrl[`CTRL_ACK] ? (ack ? 1'b0 : pending) : live;

    // Relay, colour and display outputs registered, so pins never glitch on decode changes
    always @(posedge clk) begin
        if (srst) begin
            relay_out <= 2'b00;
            pending <= 1'b0;
            alarm_q <= 1'b0;
            extra_q <= 1'b0;
            colour_red <= 1'b0;
            colour_green <= 1'b1;
            displayed_value <= 16'h0000;
        end else if (ce) begin
            relay_out <= next_relay;
            pending <= next_pending;
            alarm_q <= alarm_live;
            extra_q <= extra_live;
            colour_red <= ctrl[`CTRL_RED] ^ next_pending;
            colour_green <= ~(ctrl[`CTRL_RED] ^ next_pending);
            displayed_value <= ctrl[`CTRL_DISPLAYED_VALUE_SELECT] ? held : measured_value;
        end
    end
endmodule

// >>> shared/relay_ctrl_map.vh
// Function
// - Inactive mode holds relay off, alarm aside
// - Direct mode: on above, off below band
// - Inverted mode: off above, on below band
// - Inside window: on between inner borders
// - Outside window: on beyond outer borders
// - Window limits are max/min of thresholds
// - Signed thresholds, hysteresis symmetric about each
// - Serial mode follows serial commands only
// - Indicator LED lights while relay closed
// - Turn on after uninterrupted on-delay
// - Turn off after uninterrupted off-delay
// - Short border crossings restart delay count
// - Delay unit is seconds or minutes; code steps in 0.1 s or 6 s units
// - Critical situation applies per-relay alarm reaction
// - Critical: range exceeded, or frame gap
// - Forced-on alarm overrides inactive mode
// - Basic colour, other colour on events
// - Relay and alarm colour event enables
// - Extra colour threshold, rising or falling
// - Key press acknowledges colour events when enabled
// - Peak needs rise-then-fall by minimum change
// - Peak hold time; zero special per mode
// - Per-relay current or peak value source
// - Frame timeout 0-99 s, zero disables
`ifndef RELAY_CTRL_MAP_VH
`define RELAY_CTRL_MAP_VH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_TIME 8'h04
`define OFF_CTHR 8'h08
`define OFF_PMIN 8'h0c
`define OFF_STAT 8'h10
`define OFF_RELAY 3'b001
`define OFF_RCFG 2'b00
`define OFF_RTHR 2'b01
`define OFF_RDLY 2'b10
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_RED 0
`define CTRL_CAL 1
`define CTRL_CPR 2
`define CTRL_DIR 3
`define CTRL_ACK 4
`define CTRL_DISPLAYED_VALUE_SELECT 5
`define CTRL_INV 6
`define RCFG_UNIT 5
`define RCFG_SRC 6
`define RCFG_CFOL 7
// ----------------------------------------
// Relay modes and alarm reactions
// ----------------------------------------
`define MODE_INACT 3'h0
`define MODE_DIRECT 3'h1
`define MODE_INVERT 3'h2
`define MODE_INSIDE 3'h3
`define MODE_OUTSIDE 3'h4
`define MODE_SERIAL 3'h5
`define REACT_KEEP 2'h0
`define REACT_ON 2'h1
`define REACT_OFF 2'h2
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_NS 20
`define TICK_NS 100000000
`define TICKS_PER_SEC 4'h9
`define TICKS_PER_MIN_STEP 6'h3b
`define TMO_MAX 7'h7f
`endif

// >>> tb/relay_ctrl_sva.sv
`include "relay_ctrl_map.vh"
module relay_ctrl_sva #(
    parameter TICK_CYCLES = 10 // Cycles per 0.1 s step
) (
    input wire logic clk, // Clock
    input wire logic srst, // Sync reset
    input wire logic ce, // Clock enable
    input wire logic pslverr, // APB error
    input wire logic [1:0] relay_out, // Relay drive
    input wire logic [1:0] relay_led, // Indicator LEDs
    input wire logic colour_red, // Display red
    input wire logic colour_green, // Display green
    input wire logic [15:0] displayed_value // Shown value
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Output relations
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_led_copy;
        relay_led == relay_out;
    endproperty
    a_led_copy: assert property (p_led_copy) else $error("indicator differs from relay");
    property p_one_colour;
        colour_red != colour_green;
    endproperty
    a_one_colour: assert property (p_one_colour) else $error("display colour not exclusive");
    // Reset is checked with its own disable so it cannot hide itself
    property p_reset_clear;
        disable iff (1'b0) srst |=> relay_out == 2'b00 && colour_green && !colour_red && displayed_value == 16'h0000;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("reset left state behind");
    property p_off_after_reset;
        $fell(srst) |-> (relay_out == 2'b00) [*2];
    endproperty
    a_off_after_reset: assert property (p_off_after_reset) else $error("relay closed after reset");
    property p_green_after_reset;
        $fell(srst) |-> colour_green && !colour_red;
    endproperty
    a_green_after_reset: assert property (p_green_after_reset) else $error("basic colour wrong");
    property p_relay_frozen;
        !ce |=> $stable(relay_out);
    endproperty
    a_relay_frozen: assert property (p_relay_frozen) else $error("relay moved while frozen");
    property p_colour_frozen;
        !ce |=> $stable(colour_red);
    endproperty
    a_colour_frozen: assert property (p_colour_frozen) else $error("colour moved while frozen");
    property p_display_frozen;
        $changed(displayed_value) |-> $past(ce);
    endproperty
    a_display_frozen: assert property (p_display_frozen) else $error("display moved while frozen");
    c_relay_closed: cover property ($rose(relay_out[0]));
    c_red: cover property ($rose(colour_red));
    c_err: cover property (pslverr);
endmodule
bind threshold_relay_controller relay_ctrl_sva #(.TICK_CYCLES(TICK_CYCLES)) relay_ctrl_sva_i (
    .clk(clk), .srst(srst), .ce(ce), .pslverr(pslverr), .relay_out(relay_out), .relay_led(relay_led),
    .colour_red(colour_red), .colour_green(colour_green), .displayed_value(displayed_value));

// >>> tb/relay_load_model.sv
module relay_load_model (
    input wire logic clk, // Clock
    input wire logic [1:0] relay_out, // Relay coil drive
    output logic [7:0] closures // Relay one closings
);
    timeunit 1ns;
    timeprecision 1ps;
    logic prev = 1'b0;
    logic [7:0] count = 8'h00;
    assign closures = count;
    // Count contact closings; bounces would show as extra counts
    always @(posedge clk) begin
        prev <= relay_out[0];
        if (relay_out[0] === 1'b1 && prev === 1'b0)
            count <= count + 8'h01;
    end
endmodule

// >>> tb/tb_top.sv
`include "relay_ctrl_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] measured_value = 16'h0;
    logic range_exceeded = 1'b0;
    logic frame_received = 1'b0;
    logic escape_key = 1'b0;
    logic serial_cmd_valid = 1'b0;
    logic [1:0] serial_relay_cmd = 2'b00;
    logic key_press = 1'b0;
    logic [1:0] relay_out;
    logic [1:0] relay_led;
    logic colour_red;
    logic colour_green;
    logic [15:0] displayed_value;
    logic [7:0] closures;
    logic [31:0] rd;
    logic err;
    int failures = 0;
    int checked = 0;
    int n;
    always #10 clk = ~clk;
    // ----------------------------------------
    // Design and load
    // ----------------------------------------
    threshold_relay_controller #(.TICK_CYCLES(10)) threshold_relay_controller_i (
        .clk(clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .measured_value(measured_value),
        .range_exceeded(range_exceeded), .frame_received(frame_received), .serial_cmd_valid(serial_cmd_valid),
        .serial_relay_cmd(serial_relay_cmd), .key_press(key_press), .escape_key(escape_key), .relay_out(relay_out),
        .relay_led(relay_led), .colour_red(colour_red), .colour_green(colour_green),
        .displayed_value(displayed_value));
    relay_load_model relay_load_model_i (.clk(clk), .relay_out(relay_out), .closures(closures));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One APB transfer; the idle edge at the end avoids double drives
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic step(input logic [15:0] v, input logic e);
        measured_value <= v;
        repeat (4) @(posedge clk);
        chk("relay_one", 32'(e), 32'(relay_out[0]));
    endtask
    task automatic pulse_key;
        key_press <= 1'b1;
        @(posedge clk);
        key_press <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    task automatic send_cmd(input logic [1:0] c);
        serial_relay_cmd <= c;
        serial_cmd_valid <= 1'b1;
        @(posedge clk);
        serial_cmd_valid <= 1'b0;
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Watchdog well beyond the roughly six hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        wrap_up();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        chk("relay_reset", 32'h0, 32'(relay_out));
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk("ctrl_reset", 32'h0, rd);
        apb(1'b0, 8'h2c, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        apb(1'b1, 8'h24, 32'h012c0064);
        apb(1'b1, 8'h20, 32'h000a0001);
        step(16'd95, 1'b0);
        ce <= 1'b0;
        measured_value <= 16'd111;
        repeat (8) @(posedge clk);
        chk("frozen", 32'h0, 32'(relay_out[0]));
        ce <= 1'b1;
        step(16'd111, 1'b1);
        chk("display_live", 32'd111, 32'(displayed_value));
        step(16'd95, 1'b1);
        step(16'd89, 1'b0);
        chk("closures", 32'h1, 32'(closures));
        apb(1'b1, 8'h24, 32'h0000ffce);
        step(16'hffe2, 1'b1);
        step(16'hffba, 1'b0);
        apb(1'b1, 8'h24, 32'h012c0064);
        apb(1'b1, 8'h20, 32'h000a0002);
        step(16'd111, 1'b0);
        step(16'd95, 1'b0);
        step(16'd89, 1'b1);
        // Reversed threshold order must give the same window
        apb(1'b1, 8'h24, 32'h0064012c);
        apb(1'b1, 8'h20, 32'h000a0003);
        step(16'd150, 1'b1);
        step(16'd305, 1'b1);
        step(16'd320, 1'b0);
        step(16'd200, 1'b1);
        step(16'd95, 1'b1);
        step(16'd80, 1'b0);
        apb(1'b1, 8'h20, 32'h000a0004);
        step(16'd320, 1'b1);
        step(16'd200, 1'b0);
        step(16'd80, 1'b1);
        apb(1'b1, 8'h20, 32'h00000005);
        send_cmd(2'b10);
        step(16'd5000, 1'b0);
        chk("relay_two", 32'h0, 32'(relay_out[1]));
        send_cmd(2'b01);
        step(16'd80, 1'b1);
        // Serial relay with forced-off alarm; only the frame gap can open it
        apb(1'b1, 8'h20, 32'h00000015);
        frame_received <= 1'b1;
        @(posedge clk);
        frame_received <= 1'b0;
        apb(1'b1, `OFF_TIME, 32'h00000001);
        repeat (150) @(posedge clk);
        chk("frame_in_time", 32'h1, 32'(relay_out[0]));
        repeat (100) @(posedge clk);
        chk("frame_gap", 32'h0, 32'(relay_out[0]));
        apb(1'b1, `OFF_TIME, 32'h00000000);
        apb(1'b1, 8'h20, 32'h00000008);
        step(16'd5000, 1'b0);
        range_exceeded <= 1'b1;
        step(16'd5000, 1'b1);
        range_exceeded <= 1'b0;
        step(16'd5000, 1'b0);
        apb(1'b1, 8'h20, 32'h000a0011);
        step(16'd5000, 1'b1);
        range_exceeded <= 1'b1;
        step(16'd5000, 1'b0);
        range_exceeded <= 1'b0;
        step(16'd50, 1'b0);
        // Turn-on delay of 5 steps, interrupted once to restart it
        apb(1'b1, 8'h24, 32'h012c0064);
        apb(1'b1, 8'h28, 32'h00000005);
        measured_value <= 16'd111;
        repeat (20) @(posedge clk);
        chk("delay_early", 32'h0, 32'(relay_out[0]));
        measured_value <= 16'd50;
        repeat (5) @(posedge clk);
        measured_value <= 16'd111;
        repeat (38) @(posedge clk);
        chk("delay_restart", 32'h0, 32'(relay_out[0]));
        n = 0;
        while (relay_out[0] !== 1'b1 && n < 60) begin
            @(posedge clk);
            n++;
        end
        chk("delay_on", 32'h1, 32'(relay_out[0]));
        apb(1'b1, `OFF_CTRL, 32'h00000012);
        range_exceeded <= 1'b1;
        repeat (4) @(posedge clk);
        chk("colour_alarm", 32'h1, 32'(colour_red));
        range_exceeded <= 1'b0;
        repeat (4) @(posedge clk);
        chk("colour_latched", 32'h1, 32'(colour_red));
        pulse_key();
        chk("colour_ack", 32'h0, 32'(colour_red));
        apb(1'b1, `OFF_CTRL, 32'h00000002);
        range_exceeded <= 1'b1;
        repeat (4) @(posedge clk);
        pulse_key();
        chk("colour_no_ack", 32'h1, 32'(colour_red));
        range_exceeded <= 1'b0;
        repeat (4) @(posedge clk);
        chk("colour_live", 32'h0, 32'(colour_red));
        apb(1'b1, `OFF_CTRL, 32'h00000001);
        repeat (4) @(posedge clk);
        chk("basic_red", 32'h1, 32'(colour_red));
        chk("basic_green", 32'h0, 32'(colour_green));
        // Peak of 200 held in hold display mode until escape
        apb(1'b1, `OFF_PMIN, 32'h0000000a);
        apb(1'b1, `OFF_CTRL, 32'h00000020);
        step(16'd200, 1'b1);
        step(16'd150, 1'b1);
        chk("peak_held", 32'd200, 32'(displayed_value));
        escape_key <= 1'b1;
        @(posedge clk);
        escape_key <= 1'b0;
        repeat (4) @(posedge clk);
        chk("peak_escape", 32'd150, 32'(displayed_value));
        // A second reset in mid-run must drop the closed relay again
        srst <= 1'b1;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        chk("relay_reset_again", 32'h0, 32'(relay_out));
        chk("display_reset", 32'h0, 32'(displayed_value));
        repeat (4) @(posedge clk);
        wrap_up();
    end
endmodule
